// ---- verilog/bps_top.sv ----
// Purpose: protection and restart sequencing for a ballast half-bridge controller
// Assumes: inputs are comparator levels with hysteresis already applied
// Notes:   one clock; gate outputs alternate with a fixed dead band
`timescale 1ns/1ps
`default_nettype none
module bps_top
  import bps_pkg::*;
#(
  parameter int unsigned HALF_CYC = BPS_HALF_PERIOD_CYC,
  parameter int unsigned DEAD_CYC = BPS_GATE_DEAD_CYC
) (
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  input  wire logic supply_ok_in,
  input  wire logic bus_voltage_sense_in,
  input  wire logic lamp_shutdown_sense_in,
  input  wire logic preheat_timing_node_in,
  input  wire logic ignite_end_in,
  input  wire logic overcurrent_level_set_in,
  input  wire logic cs_neg_trip_in,
  output logic      high_side_gate_out,
  output logic      low_side_gate_out,
  output logic      osc_enable_out,
  output logic      micropower_out,
  output logic      preheat_hold_out,
  output logic      run_resistor_on_out,
  output logic      fault_latch_out
);
  logic       rst_s1_q, rst_s2_q;
  logic [6:0] s1_q, s2_q;
  bps_sense_t sn;
  bps_state_t state_q;
  logic       fault_q, pos_arm_q, neg_arm_q, sd_prev_q, lo_prev_q;
  logic       phase_q, restart_q;
  logic [BPS_CNT_W-1:0] cnt_q;
  logic       running, lo_fall, trip, live;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Two-stage sync for all comparator levels
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
    end else begin
      s1_q <= {supply_ok_in, bus_voltage_sense_in, lamp_shutdown_sense_in,
               preheat_timing_node_in, ignite_end_in, overcurrent_level_set_in,
               cs_neg_trip_in};
      s2_q <= s1_q;
    end
  end
  // Bus comparator input already carries its 2 V band, so a plain level suffices
  assign sn = bps_sense_t'(s2_q);

  assign running = (state_q != BPS_ST_OFF) && (state_q != BPS_ST_FAULT);
  // Latched fault cuts drive on the very edge it shows, not one later
  assign live    = running && !fault_q;
  assign lo_fall = lo_prev_q && !low_side_gate_out;
  // Checked each switching cycle; one bad cycle is enough
  assign trip = (pos_arm_q && sn.cs_pos_trip) ||
                (neg_arm_q && lo_fall && sn.cs_neg_trip);

  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      sd_prev_q <= 1'b0;
      lo_prev_q <= 1'b0;
    end else begin
      sd_prev_q <= sn.shutdown_hi;
      lo_prev_q <= low_side_gate_out;
    end
  end

  // Fault latch; clears take priority since the device is held off anyway
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      fault_q <= 1'b0;
    end else if (sn.shutdown_hi || !sn.supply_ok) begin
      fault_q <= 1'b0;
    end else if (running && trip) begin
      fault_q <= 1'b1;
    end
  end

  // Internal restart pulse when shutdown sense falls back low
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= sd_prev_q && !sn.shutdown_hi;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q <= BPS_ST_OFF;
    end else if (fault_q) begin
      state_q <= BPS_ST_FAULT;
    end else if (sn.shutdown_hi || !sn.supply_ok || !sn.bus_ok || restart_q ||
                 (sd_prev_q && !sn.shutdown_hi)) begin
      // Cause and pulse both hold OFF, so no stray start slips in ahead of the pulse
      state_q <= BPS_ST_OFF;
    end else begin
      case (state_q)
        BPS_ST_OFF: begin
          if (sn.supply_ok && sn.bus_ok && !sn.shutdown_hi) begin
            state_q <= BPS_ST_STARTUP;
          end
        end
        BPS_ST_STARTUP: state_q <= BPS_ST_PREHEAT;
        BPS_ST_PREHEAT: begin
          if (sn.preheat_end) begin
            state_q <= BPS_ST_IGNITE;
          end
        end
        BPS_ST_IGNITE: begin
          if (sn.ignite_end) begin
            state_q <= BPS_ST_RUN;
          end
        end
        BPS_ST_RUN:   state_q <= BPS_ST_RUN;
        BPS_ST_FAULT: state_q <= BPS_ST_OFF;
        default:      state_q <= BPS_ST_OFF;
      endcase
    end
  end

  // Arming follows mode; leaving to OFF clears both
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      pos_arm_q <= 1'b0;
      neg_arm_q <= 1'b0;
    end else if (!running) begin
      pos_arm_q <= 1'b0;
      neg_arm_q <= 1'b0;
    end else begin
      pos_arm_q <= (state_q == BPS_ST_IGNITE) || (state_q == BPS_ST_RUN);
      neg_arm_q <= (state_q == BPS_ST_RUN);
    end
  end

  // Fixed oscillator: half period, with dead band at start of each half
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end else if (!running) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end else if (cnt_q >= BPS_CNT_W'(HALF_CYC - 1)) begin
      cnt_q   <= '0;
      phase_q <= !phase_q;
    end else begin
      cnt_q   <= cnt_q + 1'b1;
    end
  end

  // Gates forced low whenever not live
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      high_side_gate_out <= 1'b0;
      low_side_gate_out  <= 1'b0;
    end else begin
      high_side_gate_out <= live && phase_q && (cnt_q >= BPS_CNT_W'(DEAD_CYC));
      low_side_gate_out  <= live && !phase_q && (cnt_q >= BPS_CNT_W'(DEAD_CYC));
    end
  end

  // Mode status pins
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      osc_enable_out      <= 1'b0;
      micropower_out      <= 1'b1;
      preheat_hold_out    <= 1'b0;
      run_resistor_on_out <= 1'b0;
    end else begin
      osc_enable_out      <= live;
      micropower_out      <= !live;
      preheat_hold_out    <= live &&
                             ((state_q == BPS_ST_STARTUP) || (state_q == BPS_ST_PREHEAT));
      run_resistor_on_out <= live && (state_q == BPS_ST_RUN);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      fault_latch_out <= 1'b0;
    end else begin
      fault_latch_out <= fault_q;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/bps_pkg.sv ----
// Purpose: shared constants and types for the ballast protection sequencer
// Assumes: comparator outputs arrive as asynchronous digital levels
// Notes:   hysteresis figures are kept for reference; comparators apply them
package bps_pkg;
  localparam int unsigned BPS_CLK_HZ          = 25000000;
  localparam int unsigned BPS_GATE_DEAD_NS    = 400;
  localparam int unsigned BPS_GATE_DEAD_CYC   =
    (BPS_GATE_DEAD_NS * (BPS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned BPS_HALF_PERIOD_NS  = 10000;
  localparam int unsigned BPS_HALF_PERIOD_CYC =
    (BPS_HALF_PERIOD_NS * (BPS_CLK_HZ / 1000000)) / 1000;
  localparam int unsigned BPS_CNT_W           = 16;
  localparam int unsigned BPS_BUS_HYST_MV     = 2000;
  localparam int unsigned BPS_SD_HYST_MV      = 150;

  typedef enum logic [2:0] {
    BPS_ST_OFF     = 3'b000,
    BPS_ST_STARTUP = 3'b001,
    BPS_ST_PREHEAT = 3'b011,
    BPS_ST_IGNITE  = 3'b010,
    BPS_ST_RUN     = 3'b110,
    BPS_ST_FAULT   = 3'b111
  } bps_state_t;

  typedef struct packed {
    logic supply_ok;
    logic bus_ok;
    logic shutdown_hi;
    logic preheat_end;
    logic ignite_end;
    logic cs_pos_trip;
    logic cs_neg_trip;
  } bps_sense_t;
endpackage

// ---- testbench/bps_props.sv ----
// Purpose: port checker for bps_top
// Assumes: about four edges from input to output
// Notes:   bound after the module
`timescale 1ns/1ps
`default_nettype none
module bps_props (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic supply_ok_in,
  input wire logic bus_voltage_sense_in,
  input wire logic lamp_shutdown_sense_in,
  input wire logic overcurrent_level_set_in,
  input wire logic high_side_gate_out,
  input wire logic low_side_gate_out,
  input wire logic osc_enable_out,
  input wire logic micropower_out,
  input wire logic preheat_hold_out,
  input wire logic run_resistor_on_out,
  input wire logic fault_latch_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence bus_gone; !bus_voltage_sense_in [*6]; endsequence
  sequence lamp_out; lamp_shutdown_sense_in [*6]; endsequence
  sequence neg_only; !overcurrent_level_set_in [*8] ##1 $rose(fault_latch_out); endsequence
  wire logic quiet = !osc_enable_out && !high_side_gate_out && !low_side_gate_out;
  start_cond_a: assert property ($rose(osc_enable_out) |->
    $past(supply_ok_in && bus_voltage_sense_in && !lamp_shutdown_sense_in, 3))
    else $error("oscillator started without all start conditions");
  bus_stop_a: assert property (bus_gone |-> quiet)
    else $error("switching with bus low");
  restart_first_a: assert property ($rose(osc_enable_out) |->
    preheat_hold_out && !run_resistor_on_out) else $error("restart not in first mode");
  sd_off_a: assert property (lamp_out |-> quiet && micropower_out && !fault_latch_out)
    else $error("shutdown sense high but not off");
  fault_off_a: assert property (fault_latch_out |-> quiet && micropower_out)
    else $error("fault latched but still switching");
  pos_arm_a: assert property ($rose(fault_latch_out) |-> !$past(preheat_hold_out))
    else $error("fault taken during startup or preheat");
  neg_arm_a: assert property (neg_only |-> $past(run_resistor_on_out))
    else $error("negative trip outside run mode");
  supply_clr_a: assert property (!supply_ok_in [*6] |-> !fault_latch_out && quiet)
    else $error("fault latch kept with supply low");
endmodule
bind bps_top bps_props u_props (.*);
`default_nettype wire

// ---- testbench/bps_stage.sv ----
// Purpose: half-bridge stage and lamp sense model
// Assumes: sense resistor in the low leg
// Notes:   current shows only while the low gate conducts
`timescale 1ns/1ps
`default_nettype none
module bps_stage (
  input  wire logic low_side_gate_out,
  input  wire logic lamp_in,
  input  wire logic oc_cmd,
  input  wire logic neg_cmd,
  output logic      lamp_shutdown_sense_in,
  output logic      overcurrent_level_set_in,
  output logic      cs_neg_trip_in
);
  assign lamp_shutdown_sense_in = !lamp_in;
  // No current path with the low switch off
  assign overcurrent_level_set_in = oc_cmd & low_side_gate_out;
  assign cs_neg_trip_in = neg_cmd & low_side_gate_out;
endmodule
`default_nettype wire

// ---- testbench/tb_ballast_protection_sequencer.sv ----
// Purpose: self-checking bench for bps_top
// Assumes: short half period and dead band
// Notes:   mode model 0 off, 1 preheat, 2 ignite, 3 run, 4 fault
`timescale 1ns/1ps
`default_nettype none
module tb_ballast_protection_sequencer;
  logic mclk_in = 0, rst_b_in = 0, supply_ok_in = 0, bus_voltage_sense_in = 0;
  logic preheat_timing_node_in = 0, ignite_end_in = 0, lamp_in = 1, oc_cmd = 0, neg_cmd = 0;
  logic lamp_shutdown_sense_in, overcurrent_level_set_in, cs_neg_trip_in, high_side_gate_out;
  logic low_side_gate_out, osc_enable_out, micropower_out, preheat_hold_out;
  logic run_resistor_on_out, fault_latch_out;
  int   err_total = 0, checked = 0, cyc = 0, m;
  always #20 mclk_in = ~mclk_in;
  bps_top #(.HALF_CYC(8), .DEAD_CYC(2)) dut (.*);
  bps_stage u_stage (.*);
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string name, logic seen, logic exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %b seen %b", name, exp, seen);
    end
  endtask
  task automatic step(int n, int mode);
    repeat (n) @(negedge mclk_in);
    m = mode;
    chk("osc", osc_enable_out, m inside {[1:3]});
    chk("micro", micropower_out, !(m inside {[1:3]}));
    chk("hold", preheat_hold_out, m == 1);
    chk("run", run_resistor_on_out, m == 3);
    chk("fault", fault_latch_out, m == 4);
    chk("overlap", high_side_gate_out & low_side_gate_out, 1'b0);
    if (!(m inside {[1:3]})) begin
      chk("hs", high_side_gate_out, 1'b0);
      chk("ls", low_side_gate_out, 1'b0);
    end
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(57));
    repeat (20) @(negedge mclk_in);
    rst_b_in = 1;
    step(6, 0);
    supply_ok_in = 1;
    step(10, 0);
    bus_voltage_sense_in = 1;
    step(10, 1);
    repeat (20) begin
      oc_cmd = 1'($urandom);
      @(negedge mclk_in);
    end
    oc_cmd = 1;
    step(30, 1);
    oc_cmd = 0;
    preheat_timing_node_in = 1;
    step(10, 2);
    ignite_end_in = 1;
    step(10, 3);
    bus_voltage_sense_in = 0;
    preheat_timing_node_in = 0;
    ignite_end_in = 0;
    step(10, 0);
    bus_voltage_sense_in = 1;
    step(10, 1);
    preheat_timing_node_in = 1;
    step(10, 2);
    oc_cmd = 1;
    step(40, 4);
    bus_voltage_sense_in = 0;
    step(10, 4);
    bus_voltage_sense_in = 1;
    lamp_in = 0;
    oc_cmd = 0;
    preheat_timing_node_in = 0;
    step(10, 0);
    lamp_in = 1;
    step(10, 1);
    preheat_timing_node_in = 1;
    neg_cmd = 1;
    step(40, 2);
    ignite_end_in = 1;
    step(40, 4);
    supply_ok_in = 0;
    neg_cmd = 0;
    preheat_timing_node_in = 0;
    ignite_end_in = 0;
    step(10, 0);
    supply_ok_in = 1;
    step(10, 1);
    end_of_test();
  end
endmodule
`default_nettype wire
